/* verilog/tsf_status.sv */
// Converter status register with new-data flags and interrupt pin control
// Behaviour
// R1 - Two-bit read/write pin-function field in bits 15:14, reset value binary 10.
// R2 - Code 00: pin goes low only on detected pen touch.
// R3 - Code 01: pin goes low as soon as one conversion set completes.
// R4 - Code 01 in scan: pin stays low until all relevant results read.
// R5 - Code 10 or 11: low on touch, high once selected conversions finish.
// R6 - Read-only bit 13 shows converter active, reset 0.
// R7 - Read-only bit 12 shows self-controlled (1) or host-controlled (0), reset 0.
// R8 - Data-ready bit sets on completed set, clears after all results read.
// R9 - X flag sets on new X result, clears after complete read.
// R10 - Y flag sets on new Y result, clears after complete read.
// R11 - First pressure flag sets on new result, clears after complete read.
// R12 - Second pressure flag sets on new result, clears after complete read.
// R13 - First battery flag sets on new result, clears after complete read.
// R14 - Second battery flag sets on new result, clears after complete read.
// R15 - Auxiliary flag sets on new result, clears after complete read.
// R16 - First temperature flag sets on new result, clears after complete read.
// R17 - Second temperature flag sets on new result, clears after complete read.
// R18 - Reserved bits read zero; writes change only the pin-function field.
// R19 - New result in same cycle as completing read keeps flag set.
`timescale 1ns/100ps
`default_nettype none

module tsf_status
#(
    parameter int NUM_RESULTS = tsf_pkg::NUM_RESULTS
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Register port from the serial control interface
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    // Conversion engine events, same clock domain
    input wire logic [NUM_RESULTS-1:0] result_stored_in,
    input wire logic [NUM_RESULTS-1:0] result_read_done_in,
    input wire logic [NUM_RESULTS-1:0] result_selected_in,
    input wire logic set_done_in,
    input wire logic conversions_over_in,
    input wire logic converter_active_in,
    input wire logic self_control_in,
    // Pen detector, asynchronous to the clock
    input wire logic pen_touch_in,
    // Interrupt pin, active low
    output logic touch_or_ready_irq_n_out,
    // Status mirror for the rest of the device
    output logic result_set_ready_out
);

    // ------------------------------------------------------------
    // Pen input synchroniser
    // ------------------------------------------------------------
    logic pen_meta_ff;
    logic pen_sync_ff;
    logic pen_prev_ff;
    logic nxt_pen_meta;
    logic nxt_pen_sync;
    logic nxt_pen_prev;
    logic pen_rise;

    always_comb
    begin
        nxt_pen_meta = pen_touch_in;
        nxt_pen_sync = pen_meta_ff;
        nxt_pen_prev = pen_sync_ff;
        pen_rise = pen_sync_ff & ~pen_prev_ff;
    end

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            pen_meta_ff <= 1'b0;
            pen_sync_ff <= 1'b0;
            pen_prev_ff <= 1'b0;
        end
        else
        begin
            pen_meta_ff <= nxt_pen_meta;
            pen_sync_ff <= nxt_pen_sync;
            pen_prev_ff <= nxt_pen_prev;
        end
    end

    // ------------------------------------------------------------
    // Per-result new-data flags
    // ------------------------------------------------------------
    logic [NUM_RESULTS-1:0] new_flags;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_RESULTS; gi = gi + 1)
        begin : g_flag
            // [R9] [R10] [R11] [R12] [R13] [R14] [R15] [R16] [R17]
            tsf_new_flag u_flag
            (
                .clock_in(clock_in),
                .srst_in(srst_in),
                .stored_in(result_stored_in[gi]),
                .read_done_in(result_read_done_in[gi]),
                .flag_out(new_flags[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Pin-function field, data-ready bit and status bits
    // ------------------------------------------------------------
    logic [1:0] irq_sel_ff;
    logic result_set_ready_ff;
    logic converter_active_flag_ff;
    logic control_mode_flag_ff;
    logic [1:0] nxt_irq_sel;
    logic nxt_result_set_ready;
    logic nxt_converter_active_flag;
    logic nxt_control_mode_flag;
    logic status_hit;
    logic pending_any;
    logic pending_after;

    always_comb
    begin
        status_hit = (reg_addr_in == tsf_pkg::CONVERTER_STATUS_OFFSET);
        nxt_irq_sel = irq_sel_ff;
        if (reg_wr_in && status_hit)
        begin
            // Only the pin-function field is writable
            nxt_irq_sel = reg_wdata_in[tsf_pkg::IRQ_SEL_MSB:tsf_pkg::IRQ_SEL_LSB]; // [R1] [R18]
        end
        nxt_converter_active_flag = converter_active_in; // [R6]
        nxt_control_mode_flag = self_control_in; // [R7]
        // Selected results flagged now, and results still unread once this cycle's completing reads retire
        pending_any = |(new_flags & result_selected_in);
        pending_after = |((new_flags & ~result_read_done_in) | result_stored_in);
        nxt_result_set_ready = result_set_ready_ff;
        if (result_set_ready_ff && !pending_after)
        begin
            nxt_result_set_ready = 1'b0; // [R8]
        end
        if (set_done_in)
        begin
            nxt_result_set_ready = 1'b1; // [R8]
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            irq_sel_ff <= tsf_pkg::IRQ_SEL_RESET;
            result_set_ready_ff <= tsf_pkg::FLAG_RESET;
            converter_active_flag_ff <= tsf_pkg::FLAG_RESET;
            control_mode_flag_ff <= tsf_pkg::FLAG_RESET;
        end
        else
        begin
            irq_sel_ff <= nxt_irq_sel;
            result_set_ready_ff <= nxt_result_set_ready;
            converter_active_flag_ff <= nxt_converter_active_flag;
            control_mode_flag_ff <= nxt_control_mode_flag;
        end
    end

    // ------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------
    logic irq_n_ff;
    logic nxt_irq_n;
    logic touch_low_ff;
    logic nxt_touch_low;

    always_comb
    begin
        // Touch hold: set by pen edge, released when selected conversions end
        nxt_touch_low = touch_low_ff;
        if (conversions_over_in)
        begin
            nxt_touch_low = 1'b0; // [R5]
        end
        if (pen_rise)
        begin
            nxt_touch_low = 1'b1; // [R5]
        end
        unique case (irq_sel_ff)
            tsf_pkg::IRQ_SEL_PEN:
            begin
                nxt_irq_n = ~pen_sync_ff; // [R2]
            end
            tsf_pkg::IRQ_SEL_DATA:
            begin
                // Low from set completion until all relevant results are read
                nxt_irq_n = ~(nxt_result_set_ready | (result_set_ready_ff & pending_any)); // [R3] [R4]
            end
            default:
            begin
                nxt_irq_n = ~nxt_touch_low; // [R5]
            end
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            touch_low_ff <= 1'b0;
            irq_n_ff <= tsf_pkg::IRQ_PIN_RESET;
        end
        else
        begin
            touch_low_ff <= nxt_touch_low;
            irq_n_ff <= nxt_irq_n;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [15:0] status_word;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic result_set_ready_out_ff;

    always_comb
    begin
        status_word = 16'h0000; // [R18]
        status_word[tsf_pkg::IRQ_SEL_MSB:tsf_pkg::IRQ_SEL_LSB] = irq_sel_ff;
        status_word[tsf_pkg::ACTIVE_BIT] = converter_active_flag_ff;
        status_word[tsf_pkg::MODE_BIT] = control_mode_flag_ff;
        status_word[tsf_pkg::SET_READY_BIT] = result_set_ready_ff;
        status_word[tsf_pkg::X_BIT] = new_flags[tsf_pkg::CH_X];
        status_word[tsf_pkg::Y_BIT] = new_flags[tsf_pkg::CH_Y];
        status_word[tsf_pkg::PRESS_A_BIT] = new_flags[tsf_pkg::CH_PRESS_A];
        status_word[tsf_pkg::PRESS_B_BIT] = new_flags[tsf_pkg::CH_PRESS_B];
        status_word[tsf_pkg::BAT_A_BIT] = new_flags[tsf_pkg::CH_BAT_A];
        status_word[tsf_pkg::BAT_B_BIT] = new_flags[tsf_pkg::CH_BAT_B];
        status_word[tsf_pkg::AUX_BIT] = new_flags[tsf_pkg::CH_AUX];
        status_word[tsf_pkg::TEMP_A_BIT] = new_flags[tsf_pkg::CH_TEMP_A];
        status_word[tsf_pkg::TEMP_B_BIT] = new_flags[tsf_pkg::CH_TEMP_B];
        nxt_rdata = rdata_ff;
        if (reg_rd_in)
        begin
            // Other addresses belong to other blocks; this one answers zero
            nxt_rdata = status_hit ? status_word : 16'h0000;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            rdata_ff <= 16'h0000;
            result_set_ready_out_ff <= tsf_pkg::FLAG_RESET;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            result_set_ready_out_ff <= nxt_result_set_ready;
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign touch_or_ready_irq_n_out = irq_n_ff;
    assign result_set_ready_out = result_set_ready_out_ff;

endmodule

`default_nettype wire

/* verilog/tsf_pkg.sv */
// Package: offsets, field positions and reset values of the converter status register
package tsf_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CONVERTER_STATUS_OFFSET = 8'h01;
    localparam int STATUS_WIDTH = 16;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int IRQ_SEL_MSB = 15;
    localparam int IRQ_SEL_LSB = 14;
    localparam int ACTIVE_BIT = 13;
    localparam int MODE_BIT = 12;
    localparam int SET_READY_BIT = 11;
    localparam int X_BIT = 10;
    localparam int Y_BIT = 9;
    localparam int PRESS_A_BIT = 8;
    localparam int PRESS_B_BIT = 7;
    localparam int BAT_A_BIT = 6;
    localparam int BAT_B_BIT = 5;
    localparam int AUX_BIT = 4;
    localparam int TEMP_A_BIT = 2;
    localparam int TEMP_B_BIT = 1;

    // ------------------------------------------------------------
    // Result channels, index order of the new-data flag vector
    // ------------------------------------------------------------
    localparam int NUM_RESULTS = 9;
    localparam int CH_X = 0;
    localparam int CH_Y = 1;
    localparam int CH_PRESS_A = 2;
    localparam int CH_PRESS_B = 3;
    localparam int CH_BAT_A = 4;
    localparam int CH_BAT_B = 5;
    localparam int CH_AUX = 6;
    localparam int CH_TEMP_A = 7;
    localparam int CH_TEMP_B = 8;

    // ------------------------------------------------------------
    // Pin-function codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] IRQ_SEL_PEN = 2'h0;
    localparam logic [1:0] IRQ_SEL_DATA = 2'h1;
    localparam logic [1:0] IRQ_SEL_RESET = 2'h2;
    localparam logic FLAG_RESET = 1'h0;
    localparam logic IRQ_PIN_RESET = 1'h1;

endpackage

/* verilog/tsf_new_flag.sv */
// Sticky new-data flag for one result register
`timescale 1ns/100ps
`default_nettype none

module tsf_new_flag
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Events
    input wire logic stored_in,
    input wire logic read_done_in,
    // Flag
    output logic flag_out
);

    logic flag_ff;
    logic nxt_flag;

    always_comb
    begin
        nxt_flag = flag_ff;
        if (read_done_in)
        begin
            nxt_flag = 1'b0;
        end
        // A result landing on the completing read keeps the flag up
        if (stored_in)
        begin
            nxt_flag = 1'b1; // [R19]
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            flag_ff <= tsf_pkg::FLAG_RESET;
        end
        else
        begin
            flag_ff <= nxt_flag;
        end
    end

    assign flag_out = flag_ff;

endmodule

`default_nettype wire

/* verif/tsf_status_monitor.sv */
// Checker of status register and pin behaviour at the block ports
`timescale 1ns/100ps
`default_nettype none

module tsf_status_monitor
#(
    parameter int NUM_RESULTS = 9
)
(
    // Design inputs
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [NUM_RESULTS-1:0] result_stored_in,
    input wire logic [NUM_RESULTS-1:0] result_read_done_in,
    input wire logic [NUM_RESULTS-1:0] result_selected_in,
    input wire logic set_done_in,
    input wire logic conversions_over_in,
    input wire logic converter_active_in,
    input wire logic self_control_in,
    input wire logic pen_touch_in,
    // Design outputs
    input wire logic [15:0] reg_rdata_out,
    input wire logic touch_or_ready_irq_n_out,
    input wire logic result_set_ready_out
);
    // ----------------------------------------
    // Shadow of the pin-function field
    // ----------------------------------------
    logic [1:0] sel_ff;
    logic [1:0] nxt_sel;
    logic st_rd;
    assign st_rd = reg_rd_in && reg_addr_in == 8'h01;
    always_comb
    begin
        nxt_sel = sel_ff;
        if (reg_wr_in && reg_addr_in == 8'h01)
            nxt_sel = reg_wdata_in[15:14];
    end
    always_ff @(posedge clock_in)
        sel_ff <= srst_in ? 2'h2 : nxt_sel;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (srst_in);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_unmapped_zero: assert property (reg_rd_in && reg_addr_in != 8'h01 |=>
        reg_rdata_out == 16'h0000) else $error("unmapped read not zero");
    // The host read follows an event after one idle cycle, so look two cycles on
    a_x_set: assert property (result_stored_in[0] ##1 !result_read_done_in[0]
        ##1 st_rd |=> reg_rdata_out[10]) else $error("x flag not set");
    a_x_clear: assert property (result_read_done_in[0] && !result_stored_in[0]
        ##1 !result_stored_in[0] ##1 st_rd |=> !reg_rdata_out[10]) else $error("x flag not cleared");
    a_store_wins: assert property (result_stored_in[1] && result_read_done_in[1]
        ##1 !result_read_done_in[1] ##1 st_rd |=> reg_rdata_out[9]) else $error("y flag lost");
    a_ready_bit: assert property (st_rd |=>
        reg_rdata_out[11] == $past(result_set_ready_out)) else $error("ready bit differs");
    a_ready_set: assert property (set_done_in |=>
        result_set_ready_out) else $error("ready not set");
    a_pen_only: assert property ((sel_ff == 2'h0 && pen_touch_in)[*5] |->
        !touch_or_ready_irq_n_out) else $error("pen pin not low");
    a_data_low: assert property (sel_ff == 2'h1 && set_done_in |=>
        !touch_or_ready_irq_n_out) else $error("data pin not low");
    a_over_high: assert property ((sel_ff[1] && !pen_touch_in)[*5] ##0
        conversions_over_in |=> touch_or_ready_irq_n_out) else $error("pin not released");
endmodule

bind tsf_status tsf_status_monitor #(.NUM_RESULTS(NUM_RESULTS)) u_mon
(
    .clock_in(clock_in),
    .srst_in(srst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in),
    .result_stored_in(result_stored_in),
    .result_read_done_in(result_read_done_in),
    .result_selected_in(result_selected_in),
    .set_done_in(set_done_in),
    .conversions_over_in(conversions_over_in),
    .converter_active_in(converter_active_in),
    .self_control_in(self_control_in),
    .pen_touch_in(pen_touch_in),
    .reg_rdata_out(reg_rdata_out),
    .touch_or_ready_irq_n_out(touch_or_ready_irq_n_out),
    .result_set_ready_out(result_set_ready_out)
);

`default_nettype wire

/* verif/tsf_host_model.sv */
// Host processor model issuing register reads and writes
`timescale 1ns/100ps
`default_nettype none

module tsf_host_model
(
    // Clock
    input wire logic clock_in,
    // Register port
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [15:0] reg_wdata_out,
    input wire logic [15:0] reg_rdata_in
);
    initial
    begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_wdata_out = 16'h0000;
    end
    // Released lines show the inverse, so a stale value never matches
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clock_in);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(negedge clock_in);
        reg_wr_out = 1'b0;
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clock_in);
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(negedge clock_in);
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
        d = reg_rdata_in;
    endtask
endmodule

`default_nettype wire

/* verif/tsf_status_tb.sv */
// Testbench: status flags, field and pin against a bench model
`timescale 1ns/100ps
`default_nettype none

module tsf_status_tb;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] addr;
    logic wr, rd, irq_n, ready;
    logic [15:0] wdata, rdata, w;
    logic [8:0] stored = 9'h000, done = 9'h000, sel = 9'h000, mf = 9'h000;
    logic sd = 1'b0, over = 1'b0, act = 1'b0, mode = 1'b0, pen = 1'b0, mdr = 1'b0;
    logic [1:0] mfield = 2'h2;
    int mismatches = 0;
    int n_compared = 0;
    int bp [9] = '{10, 9, 8, 7, 6, 5, 4, 2, 1};

    always #5 clock_in = ~clock_in;

    tsf_host_model host (.clock_in(clock_in), .reg_addr_out(addr), .reg_wr_out(wr),
        .reg_rd_out(rd), .reg_wdata_out(wdata), .reg_rdata_in(rdata));
    tsf_status #(.NUM_RESULTS(9)) dut (.clock_in(clock_in), .srst_in(srst_in),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .result_stored_in(stored), .result_read_done_in(done),
        .result_selected_in(sel), .set_done_in(sd), .conversions_over_in(over),
        .converter_active_in(act), .self_control_in(mode), .pen_touch_in(pen),
        .touch_or_ready_irq_n_out(irq_n), .result_set_ready_out(ready));

    // ----------------------------------------
    // Bench model and helpers
    // ----------------------------------------
    function automatic logic [15:0] expw();
        logic [15:0] v;
        v = {mfield, act, mode, mdr, 11'h000};
        for (int i = 0; i < 9; i++)
            v[bp[i]] = mf[i];
        return v;
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Ready drops with the last flag; a set with no flags drops one idle cycle later
    task automatic ev(input logic [8:0] s, input logic [8:0] d, input logic sdn);
        @(negedge clock_in);
        stored = s;
        done = d;
        sd = sdn;
        mf = s | (mf & ~d);
        mdr = sdn | (mdr & (mf != 9'h000));
        @(negedge clock_in);
        stored = 9'h000;
        done = 9'h000;
        sd = 1'b0;
        mdr = mdr & (mf != 9'h000);
    endtask
    task automatic rs();
        host.rd(8'h01, w);
        chk("status", w, expw());
        chk("ready", {15'h0000, ready}, {15'h0000, mdr});
    endtask
    task automatic wpin(input logic e);
        for (int i = 0; i < 12 && irq_n !== e; i++)
            @(negedge clock_in);
        chk("pin", {15'h0000, irq_n}, {15'h0000, e});
        if (irq_n !== e)
            end_sim();
    endtask
    task automatic pen_set(input logic v);
        pen = v;
        repeat (7) @(negedge clock_in);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(15));
        repeat (3) @(negedge clock_in);
        srst_in = 1'b0;
        rs();
        wpin(1'b1);
        $display("test reset done");
        host.wr(8'h01, 16'hFFFF);
        mfield = 2'h3;
        rs();
        host.wr(8'h05, 16'h0000);
        rs();
        host.rd(8'h05, w);
        chk("unmapped", w, 16'h0000);
        $display("test field done");
        for (int i = 0; i < 9; i++)
        begin
            ev(9'h001 << i, 9'h000, 1'b1);
            rs();
            ev(9'h000, 9'h001 << i, 1'b0);
            rs();
        end
        ev(9'h1FF, 9'h000, 1'b0);
        ev(9'h1FF, 9'h1FF, 1'b0);
        rs();
        repeat (10)
        begin
            sel = 9'($urandom);
            ev(9'($urandom), 9'($urandom), 1'($urandom));
            rs();
        end
        ev(9'h000, 9'h1FF, 1'b0);
        act = 1'b1;
        mode = 1'b1;
        rs();
        act = 1'b0;
        mode = 1'b0;
        rs();
        $display("test flags done");
        host.wr(8'h01, 16'h0000);
        mfield = 2'h0;
        pen_set(1'b1);
        wpin(1'b0);
        pen_set(1'b0);
        ev(9'h001, 9'h000, 1'b1);
        wpin(1'b1);
        ev(9'h000, 9'h001, 1'b0);
        host.wr(8'h01, 16'h4000);
        mfield = 2'h1;
        sel = 9'h003;
        ev(9'h003, 9'h000, 1'b1);
        wpin(1'b0);
        ev(9'h000, 9'h001, 1'b0);
        repeat (3) @(negedge clock_in);
        wpin(1'b0);
        ev(9'h000, 9'h002, 1'b0);
        wpin(1'b1);
        rs();
        for (int m = 2; m < 4; m++)
        begin
            host.wr(8'h01, {m[1:0], 14'h3FFF});
            mfield = m[1:0];
            pen_set(1'b1);
            wpin(1'b0);
            pen_set(1'b0);
            wpin(1'b0);
            over = 1'b1;
            @(negedge clock_in);
            over = 1'b0;
            wpin(1'b1);
            rs();
        end
        $display("test pin done");
        end_sim();
    end
endmodule

`default_nettype wire
